// ---- rtl/drc_pkg.sv ----
// Constants shared by the debug run and reset control block
package drc_pkg;
  // Control register location on the debug mode access port
  localparam logic [31:0] CTRL_ADDR = 32'h0100_0004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Control field positions
  localparam int BIT_DEBUG_DISABLE = 1;
  localparam int BIT_HALT_REQ = 2;
  localparam int BIT_SYS_RESET_REQ = 3;
  localparam int BIT_CORE_HOLD = 4;
  localparam int BIT_LL_DBG_REQ = 5;
  localparam int BIT_LL_DBG_ACK = 6;
  localparam int BIT_STATUS_ACK = 7;
  localparam int CTRL_TOP = 7;
  // Synchroniser depth for link-side inputs
  localparam int SYNC_STAGES = 2;
  // Link clock period in the bench, in ns, and system clock period
  localparam int LINK_PERIOD_NS = 320;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_CYCLES = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Low-leakage recovery hold states
  typedef enum logic [0:0] {
    DRC_RUN = 1'b0,
    DRC_HOLD = 1'b1
  } drc_hold_t;
endpackage : drc_pkg

// ---- rtl/drc_link_sampler.sv ----
// Link sampler: synchronises the debug link and captures access port strobes
`timescale 1ns/100ps
module drc_link_sampler #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic swdClk,
  input wire logic [ADDR_W-1:0] apAddr,
  input wire logic [DATA_W-1:0] apWdata,
  input wire logic apWrite,
  input wire logic apRead,
  output logic [ADDR_W-1:0] capAddr,
  output logic [DATA_W-1:0] capWdata,
  output logic capWrite,
  output logic capRead
);
  localparam int W = ADDR_W + DATA_W + 3;
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic prevClk;

  // Clock and data pass the same two flops, so their relative timing survives the crossing
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= {swdClk, apWrite, apRead, apAddr, apWdata};
      stage2 <= stage1;
    end
  end

  // Rising link edge found on the second stage only
  always_ff @(posedge clk) begin
    if (reset) begin
      prevClk <= 1'b0;
      capWrite <= 1'b0;
      capRead <= 1'b0;
      capAddr <= '0;
      capWdata <= '0;
    end else begin
      prevClk <= stage2[W-1];
      capWrite <= stage2[W-1] & ~prevClk & stage2[W-2];
      capRead <= stage2[W-1] & ~prevClk & stage2[W-3];
      if (stage2[W-1] & ~prevClk) begin
        capAddr <= stage2[ADDR_W+DATA_W-1:DATA_W];
        capWdata <= stage2[DATA_W-1:0];
      end
    end
  end
endmodule : drc_link_sampler

// ---- rtl/drc_run_reset_ctrl.sv ----
// Debug port run, halt and reset control register with low-leakage recovery handshake
// Requirements this block is built to
// [R01] Halt request bit forces the core into halted debug state.
// [R02] Halt request while core sleeps wakes it straight into halt.
// [R03] System reset request bit holds the system in reset while set.
// [R04] Core hold clear: core leaves reset with system at sequencing end.
// [R05] Core hold set: core stays in reset; clearing it releases at once.
// [R06] Low-leakage request holds system in reset after next deep-stop recovery.
// [R07] Request ignored when deep-stop wakeup came from the reset pin.
// [R08] Request bit sampled on deep-stop entry, sampled value used on exit.
// [R09] With sampled request, system held in reset until acknowledge set.
// [R10] Request bit cleared by the recovery power-on reset.
// [R11] Setting acknowledge releases the system held after recovery.
// [R12] Debugger reinitialises its debug logic before setting acknowledge.
// [R13] Acknowledge may stay set; recovery power-on reset clears it.
// [R14] Status acknowledge write clears sticky low-leakage entry status; debugger toggles it.
// [R15] Bits 8 to 31 reserved, read zero, no effect.
// [R16] Secured: only system reset request usable; other control bits withheld. Bit 1 still drives debug disable when secured.
// [R17] Bit 1 forces debug disabled, overriding core debug enable.
// [R18] Register reached only via access port 1 at its fixed address.
// [R19] All control bits reset to zero on power-on reset.
`timescale 1ns/100ps
module drc_run_reset_ctrl #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic swdClk,
  input wire logic [ADDR_W-1:0] apAddr,
  input wire logic [DATA_W-1:0] apWdata,
  input wire logic apWrite,
  input wire logic apRead,
  input wire logic secured,
  input wire logic coreSleeping,
  input wire logic resetSeqDone,
  input wire logic deepStopEntry,
  input wire logic deepStopExit,
  input wire logic wakeByResetPin,
  input wire logic recoveryPor,
  output logic [DATA_W-1:0] apRdata,
  output logic apRdataValid,
  output logic haltRequest,
  output logic wakeRequest,
  output logic debugForceDisable,
  output logic systemReset,
  output logic coreReset,
  output logic statusClear
);
  logic [ADDR_W-1:0] capAddr;
  logic [DATA_W-1:0] capWdata;
  logic capWrite;
  logic capRead;
  logic [drc_pkg::CTRL_TOP:0] ctrl_reg;
  logic sampledReq_reg;
  drc_pkg::drc_hold_t hold_reg;
  drc_pkg::drc_hold_t hold_next;
  logic seqPrev_reg;
  logic coreSuspended_reg;
  logic coreSuspended_next;
  logic statusAckPrev_reg;
  logic hit;

  drc_link_sampler #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sampler (
    .clk(clk),
    .reset(reset),
    .swdClk(swdClk),
    .apAddr(apAddr),
    .apWdata(apWdata),
    .apWrite(apWrite),
    .apRead(apRead),
    .capAddr(capAddr),
    .capWdata(capWdata),
    .capWrite(capWrite),
    .capRead(capRead)
  );

  // Only the one access port address decodes; others are ignored or read zero
  assign hit = (capAddr == drc_pkg::CTRL_ADDR); // [R18]

  // Control register; secured writes reach only the reset request bit
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= drc_pkg::CTRL_RESET[drc_pkg::CTRL_TOP:0]; // [R19]
    end else begin
      if (capWrite && hit) begin
        if (secured) begin
          ctrl_reg[drc_pkg::BIT_SYS_RESET_REQ] <= capWdata[drc_pkg::BIT_SYS_RESET_REQ]; // [R16]
        end else begin
          ctrl_reg <= capWdata[drc_pkg::CTRL_TOP:0]; // [R15]
        end
      end
      // Recovery reset wins over a simultaneous link write
      if (recoveryPor) begin
        ctrl_reg[drc_pkg::BIT_LL_DBG_REQ] <= 1'b0; // [R10]
        ctrl_reg[drc_pkg::BIT_LL_DBG_ACK] <= 1'b0; // [R13]
      end
    end
  end

  // Read data: reserved bits and the unimplemented erase bit read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      apRdata <= '0;
      apRdataValid <= 1'b0;
    end else begin
      apRdataValid <= capRead;
      if (capRead) begin
        apRdata <= hit ? {{(DATA_W-drc_pkg::CTRL_TOP-1){1'b0}}, ctrl_reg[drc_pkg::CTRL_TOP:1], 1'b0} : '0; // [R15]
      end
    end
  end

  // Mode controller copy of the request, taken at deep-stop entry and kept through recovery
  always_ff @(posedge clk) begin
    if (reset) begin
      sampledReq_reg <= 1'b0;
    end else if (deepStopEntry) begin
      sampledReq_reg <= ctrl_reg[drc_pkg::BIT_LL_DBG_REQ] & ~secured; // [R08]
    end
  end

  // Recovery hold machine
  always_comb begin
    hold_next = hold_reg;
    case (hold_reg)
      drc_pkg::DRC_RUN: begin
        if (deepStopExit && sampledReq_reg && !wakeByResetPin) begin
          hold_next = drc_pkg::DRC_HOLD; // [R06] [R07]
        end
      end
      drc_pkg::DRC_HOLD: begin
        // The acknowledge is honoured in any cycle without a recovery power-on reset
        if (ctrl_reg[drc_pkg::BIT_LL_DBG_ACK] && !recoveryPor) begin
          hold_next = drc_pkg::DRC_RUN; // [R11] [R12]
        end
      end
      default: hold_next = drc_pkg::DRC_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_reg <= drc_pkg::DRC_RUN;
    end else begin
      hold_reg <= hold_next; // [R09]
    end
  end

  // Next suspension state; the core reset reads it too, so the arming edge cannot leak a one-cycle release
  always_comb begin
    coreSuspended_next = coreSuspended_reg;
    if (!ctrl_reg[drc_pkg::BIT_CORE_HOLD] || secured) begin
      coreSuspended_next = 1'b0; // [R05]
    end else if (resetSeqDone && !seqPrev_reg) begin
      coreSuspended_next = 1'b1; // [R05]
    end
  end

  // Core suspension latched at the end of sequencing; dropping the hold bit frees it at once
  always_ff @(posedge clk) begin
    if (reset) begin
      seqPrev_reg <= 1'b0;
      coreSuspended_reg <= 1'b0;
    end else begin
      seqPrev_reg <= resetSeqDone;
      coreSuspended_reg <= coreSuspended_next; // [R05]
    end
  end

  // Status acknowledge makes one clear pulse per rising edge of the bit
  always_ff @(posedge clk) begin
    if (reset) begin
      statusAckPrev_reg <= 1'b0;
      statusClear <= 1'b0;
    end else begin
      statusAckPrev_reg <= ctrl_reg[drc_pkg::BIT_STATUS_ACK];
      statusClear <= ctrl_reg[drc_pkg::BIT_STATUS_ACK] & ~statusAckPrev_reg & ~secured; // [R14]
    end
  end

  // Registered control outputs; secure mode masks the halt and wake outputs, not debug disable
  always_ff @(posedge clk) begin
    if (reset) begin
      haltRequest <= 1'b0;
      wakeRequest <= 1'b0;
      debugForceDisable <= 1'b0;
      systemReset <= 1'b0;
      coreReset <= 1'b1;
    end else begin
      haltRequest <= ctrl_reg[drc_pkg::BIT_HALT_REQ] & ~secured; // [R01] [R16]
      wakeRequest <= ctrl_reg[drc_pkg::BIT_HALT_REQ] & ~secured & coreSleeping; // [R02]
      debugForceDisable <= ctrl_reg[drc_pkg::BIT_DEBUG_DISABLE]; // [R17]
      systemReset <= ctrl_reg[drc_pkg::BIT_SYS_RESET_REQ] | (hold_next == drc_pkg::DRC_HOLD); // [R03] [R09]
      coreReset <= ~resetSeqDone | coreSuspended_next; // [R04] [R05]
    end
  end

  // Checks
  chk_halt_follows: assert property (@(posedge clk) disable iff (reset)
    (ctrl_reg[drc_pkg::BIT_HALT_REQ] && !secured) |=> haltRequest) // [R01]
    else $error("halt request not forwarded");
  chk_wake_sleep: assert property (@(posedge clk) disable iff (reset)
    wakeRequest |-> $past(coreSleeping) && haltRequest) // [R02]
    else $error("wake without sleeping core");
  chk_sysreset_held: assert property (@(posedge clk) disable iff (reset)
    ctrl_reg[drc_pkg::BIT_SYS_RESET_REQ] [*2] |-> systemReset) // [R03]
    else $error("system reset released while requested");
  chk_core_release: assert property (@(posedge clk) disable iff (reset)
    (resetSeqDone && !coreSuspended_next) |=> !coreReset) // [R04]
    else $error("core not released at sequencing end");
  chk_core_suspend: assert property (@(posedge clk) disable iff (reset)
    (resetSeqDone && !seqPrev_reg && ctrl_reg[drc_pkg::BIT_CORE_HOLD] && !secured) |=> coreReset) // [R05]
    else $error("core left reset while hold bit set");
  chk_hold_clear: assert property (@(posedge clk) disable iff (reset)
    ($fell(ctrl_reg[drc_pkg::BIT_CORE_HOLD]) && resetSeqDone && $past(resetSeqDone)) |=> !coreReset) // [R05]
    else $error("core hold clear did not release core");
  chk_pin_wake: assert property (@(posedge clk) disable iff (reset)
    (hold_reg == drc_pkg::DRC_RUN && deepStopExit && wakeByResetPin) |=> hold_reg == drc_pkg::DRC_RUN) // [R07]
    else $error("reset pin wake entered hold");
  chk_hold_entry: assert property (@(posedge clk) disable iff (reset)
    (hold_reg == drc_pkg::DRC_RUN && deepStopExit && sampledReq_reg && !wakeByResetPin) |=> systemReset) // [R06]
    else $error("recovery hold not entered");
  chk_hold_until_ack: assert property (@(posedge clk) disable iff (reset)
    (hold_reg == drc_pkg::DRC_HOLD && !ctrl_reg[drc_pkg::BIT_LL_DBG_ACK]) |=> systemReset) // [R09]
    else $error("held system released without acknowledge");
  chk_ack_release: assert property (@(posedge clk) disable iff (reset)
    (hold_reg == drc_pkg::DRC_HOLD && ctrl_reg[drc_pkg::BIT_LL_DBG_ACK] && !recoveryPor
     && !ctrl_reg[drc_pkg::BIT_SYS_RESET_REQ]) |=> !systemReset) // [R11]
    else $error("acknowledge did not release system");
  chk_por_clears: assert property (@(posedge clk) disable iff (reset)
    recoveryPor |=> !ctrl_reg[drc_pkg::BIT_LL_DBG_REQ] && !ctrl_reg[drc_pkg::BIT_LL_DBG_ACK]) // [R10]
    else $error("recovery reset did not clear handshake bits");
  chk_status_pulse: assert property (@(posedge clk) disable iff (reset)
    statusClear |=> !statusClear) // [R14]
    else $error("status clear longer than one cycle");
  chk_secure_mask: assert property (@(posedge clk) disable iff (reset)
    $past(secured) |-> !haltRequest && !statusClear) // [R16]
    else $error("non-secure function active while secured");
  chk_disable_bit: assert property (@(posedge clk) disable iff (reset)
    ##1 debugForceDisable == $past(ctrl_reg[drc_pkg::BIT_DEBUG_DISABLE])) // [R17]
    else $error("debug disable not forwarded");
endmodule : drc_run_reset_ctrl

// ---- test/drc_probe_model.sv ----
// Debug probe model: drives access port requests across the link clock
`timescale 1ns/100ps
module drc_probe_model (
  input wire logic clk,
  output logic swdClk,
  output logic [31:0] apAddr,
  output logic [31:0] apWdata,
  output logic apWrite,
  output logic apRead,
  input wire logic [31:0] apRdata,
  input wire logic apRdataValid
);
  logic [31:0] lastRd;
  // Link idles with its clock parked low and no request up
  initial begin
    swdClk = 1'b0;
    apAddr = 32'h0000_0000;
    apWdata = 32'h0000_0000;
    apWrite = 1'b0;
    apRead = 1'b0;
  end
  // One request per link clock rise, held four cycles before it and eight after it
  task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(negedge clk);
    apAddr = addr;
    apWdata = data;
    apWrite = wr;
    apRead = ~wr;
    lastRd = 32'hdead_beef; // Sentinel shows a missing answer
    repeat (4) @(negedge clk);
    swdClk = 1'b1;
    // Read data is taken at a falling edge inside the one cycle it stands; the task is its only driver
    for (int n = 0; n < 8; n++) begin
      @(negedge clk);
      if (apRdataValid === 1'b1) lastRd = apRdata;
      if (n == 3) swdClk = 1'b0;
    end
    apWrite = 1'b0;
    apRead = 1'b0;
    apAddr = ~addr; // Released lines must not keep the last value
    apWdata = ~data;
  endtask : access
endmodule : drc_probe_model

// ---- test/drc_run_reset_ctrl_tb.sv ----
// Self-checking bench for the debug run and reset control block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module drc_run_reset_ctrl_tb;
  logic clk, reset, swdClk, apWrite, apRead, secured, coreSleeping, resetSeqDone, wakeByResetPin;
  logic [31:0] apAddr, apWdata, apRdata, d;
  logic [2:0] ev;
  logic apRdataValid, haltRequest, wakeRequest, debugForceDisable, systemReset, coreReset, statusClear;
  int miscompares, tests_run, pulses, p0, seed;
  localparam logic [31:0] CA = drc_pkg::CTRL_ADDR;
  drc_run_reset_ctrl i_drc_run_reset_ctrl (.clk(clk), .reset(reset), .swdClk(swdClk), .apAddr(apAddr),
    .apWdata(apWdata), .apWrite(apWrite), .apRead(apRead), .secured(secured), .coreSleeping(coreSleeping),
    .resetSeqDone(resetSeqDone), .deepStopEntry(ev[0]), .deepStopExit(ev[2]), .wakeByResetPin(wakeByResetPin),
    .recoveryPor(ev[1]), .apRdata(apRdata), .apRdataValid(apRdataValid), .haltRequest(haltRequest),
    .wakeRequest(wakeRequest), .debugForceDisable(debugForceDisable), .systemReset(systemReset),
    .coreReset(coreReset), .statusClear(statusClear));
  drc_probe_model i_drc_probe_model (.clk(clk), .swdClk(swdClk), .apAddr(apAddr), .apWdata(apWdata),
    .apWrite(apWrite), .apRead(apRead), .apRdata(apRdata), .apRdataValid(apRdataValid));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counts status clear pulses, which must be one per acknowledge
  always @(posedge clk) begin
    if (statusClear === 1'b1) pulses++;
  end
  // Control bits show at 7:1; bit 0 and the reserved top read zero
  function automatic logic [31:0] exp_read(input logic [31:0] w);
    return {24'h00_0000, w[7:1], 1'b0};
  endfunction : exp_read
  task automatic wr(input logic [31:0] a, input logic [31:0] w);
    i_drc_probe_model.access(1'b1, a, w);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] ex);
    i_drc_probe_model.access(1'b0, a, 32'h0000_0000);
    `CHK("apRdata", ex, i_drc_probe_model.lastRd)
  endtask : rd
  // One-cycle pulse on entry (0), recovery reset (1) or exit (2)
  task automatic pulse(input int k);
    ev = 3'h1 << k;
    @(negedge clk);
    ev = 3'h0;
    repeat (2) @(negedge clk);
  endtask : pulse
  // Deep-stop round trip; request and a left-set acknowledge go in first
  task automatic recover(input logic pin, input logic hold);
    wr(CA, 32'h0000_0060);
    pulse(0);
    pulse(1);
    rd(CA, 32'h0000_0000);
    wakeByResetPin = pin;
    pulse(2);
    `CHK("systemReset hold", hold, systemReset)
    // Debugger reinitialises its own debug logic here, before acknowledging
    wr(CA, 32'h0000_0040);
    `CHK("systemReset ack", 1'b0, systemReset)
  endtask : recover
  task automatic test_done();
    $display("Checks run %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // Guards against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    {reset, secured, coreSleeping, resetSeqDone, wakeByResetPin, ev} = 8'h80;
    seed = $urandom(41722);
    repeat (10) @(negedge clk);
    `CHK("coreReset", 1'b1, coreReset)
    reset = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("coreReset seq", 1'b1, coreReset)
    resetSeqDone = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("coreReset run", 1'b0, coreReset)
    rd(CA, 32'h0000_0000);
    // Random control words, with sleep state varied alongside
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'hffff_ffff : $urandom();
      coreSleeping = d[0];
      wr(CA, d);
      rd(CA, exp_read(d));
      `CHK("haltRequest", d[2], haltRequest)
      `CHK("wakeRequest", d[2] & d[0], wakeRequest)
      `CHK("systemReset", d[3], systemReset)
      `CHK("debugForceDisable", d[1], debugForceDisable)
    end
    wr(CA, 32'h0000_0000);
    wr(32'h0100_0008, 32'h0000_00ff);
    wr(32'h0000_0004, 32'h0000_00ff);
    rd(CA, 32'h0000_0000);
    rd(32'h0100_0008, 32'h0000_0000);
    // Debugger both sets and clears the status acknowledge
    p0 = pulses;
    wr(CA, 32'h0000_0080);
    wr(CA, 32'h0000_0000);
    `CHK("statusClear", 1, pulses - p0)
    secured = 1'b1;
    wr(CA, 32'h0000_00ff);
    `CHK("secure halt", 1'b0, haltRequest)
    `CHK("secure reset", 1'b1, systemReset)
    secured = 1'b0;
    wr(CA, 32'h0000_0000);
    `CHK("reset cleared", 1'b0, systemReset)
    wr(CA, 32'h0000_0010);
    resetSeqDone = 1'b0;
    repeat (3) @(negedge clk);
    resetSeqDone = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("core held", 1'b1, coreReset)
    wr(CA, 32'h0000_0000);
    `CHK("core freed", 1'b0, coreReset)
    recover(1'b0, 1'b1);
    recover(1'b1, 1'b0);
    test_done();
  end
endmodule : drc_run_reset_ctrl_tb
